/* File: hdl/scfp_map.svh */
`ifndef SCFP_MAP_SVH
`define SCFP_MAP_SVH
// Register byte addresses
`define SCFP_CLKCFG_ADDR   24'hFFF910
`define SCFP_MODULE_STATUS_ADDR    24'hFFF914
`define SCFP_IO_ZONE_TIMING_CONFIG_ADDR    24'hFFF918
`define SCFP_PB0WE_ADDR    24'hFFF91C
`define SCFP_PB1WE_ADDR    24'hFFF920
`define SCFP_DBWE_ADDR     24'hFFF924
`define SCFP_PROT_ADDR     24'hFFF928
// Reset values
`define SCFP_CLKCFG_RST    8'h00
`define SCFP_IO_ZONE_TIMING_CONFIG_RST     8'h00
`define SCFP_WE_RST        16'h0000
// Clock-output config fields
`define SCFP_EXT_BUS_BIT   0
`define SCFP_PLL_OE_BIT    1
`define SCFP_MAIN_OE_BIT   2
`define SCFP_SLOW_OE_BIT   3
`define SCFP_MISC_SLEW_BIT 5
`define SCFP_MEM_SLEW_BIT  6
`define SCFP_CLKCFG_MASK   8'h6F
// Module status fields
`define SCFP_ANY_BUSY_BIT  3
`define SCFP_DATA_BUSY_BIT 4
// I/O zone timing fields
`define SCFP_IO_WAIT_LSB   0
`define SCFP_IO_HOLD_LSB   3
`define SCFP_IO_PRE_BIT    5
`define SCFP_IO_ZONE_TIMING_CONFIG_MASK    8'h3F
// Fixed peripheral timing
`define SCFP_PERI_WAIT     3'h1
`define SCFP_PERI_HOLD     2'h0
`define SCFP_PERI_PRE      1'b1
// Address ranges
`define SCFP_PERI0_LO      24'h0EF000
`define SCFP_PERI0_HI      24'h0EF1FF
`define SCFP_PERI1_LO      24'hFF0000
`define SCFP_PERI1_HI      24'hFFFBFF
`define SCFP_IOZ_LO        24'hFFFB00
`define SCFP_IOZ_HI        24'hFFFBFF
`define SCFP_PM0_LO        24'h000000
`define SCFP_PM0_HI        24'h01FFFF
`define SCFP_PM1_LO        24'h020000
`define SCFP_PM1_HI        24'h03FFFF
`define SCFP_DM_LO         24'h0E0000
`define SCFP_DM_HI         24'h0E1FFF
`define SCFP_BOOT_MAX_END  24'h001C00
// Section index positions
`define SCFP_PM_SEC_LSB    13
`define SCFP_DM_SEC_LSB    9
// Settle cycles of the strap synchroniser
`define SCFP_STRAP_CYC     2'h2
`endif

/* File: hdl/scfp_pkg.sv */
package scfp_pkg;
	// CPU access seen by the checker
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [23:0] addr;
	} scfp_cpu_req_t;
	// Access timing for one CPU access
	typedef struct packed {
		logic       valid;
		logic [2:0] wait_cyc;
		logic [1:0] hold_cyc;
		logic       pre_idle;
		logic       ext_bus;
	} scfp_timing_t;
	// Protection word from nonvolatile storage
	typedef struct packed {
		logic [2:0]  wr_lock;
		logic [2:0]  rd_lock;
		logic [23:0] boot_end;
	} scfp_prot_t;
	// Bus slave phases
	typedef enum logic {
		SCFP_IDLE,
		SCFP_RESP
	} scfp_apb_st_t;
endpackage : scfp_pkg

/* File: hdl/scfp_top.sv */
`timescale 1ns/1ps
`include "scfp_map.svh"
// What this block does
// - Peripheral access: one wait, one idle
// - I/O zone timing from its register
// - Clock config byte, kept in power modes
// - Bit 0 enables I/O zone bus
// - Bit 1 drives PLL clock, strap 0
// - Bit 2 drives main clock, strap 1
// - Bit 3 drives slow clock, strap 2
// - Bit 5 selects misc pin slew
// - Bit 6 selects memory pin slew
// - Straps caught at reset, held after
// - Status bit 3 mirrors program flash busy
// - Status bit 4 mirrors data flash busy
// - Boot area writes always blocked
// - Writes need section enable, no lock
// - Section enables reset to zero
// - Majority-zero write lock blocks writes
// - Majority-zero read lock blocks debugger
// - Decode program and data block ranges
// - Bit 0 is lowest address section
module scfp_top (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [23:0]            paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire scfp_pkg::scfp_cpu_req_t cpu_req,
	output scfp_pkg::scfp_timing_t      cpu_timing,
	output logic                        flash_wr_allow,
	output logic                        flash_wr_deny,
	output logic                        dbg_rd_block,
	input  wire scfp_pkg::scfp_prot_t   prot_word,
	input  wire logic                   prog_flash_busy,
	input  wire logic                   data_flash_busy,
	input  wire logic [2:0]             env_strap_in,
	output logic      [2:0]             env_strap_out,
	output logic      [2:0]             env_strap_oe,
	input  wire logic                   pll_clk_lvl,
	input  wire logic                   main_clk_lvl,
	input  wire logic                   slow_clk_lvl,
	output logic                        io_zone_ext_bus_en,
	output logic                        misc_pin_slew_sel,
	output logic                        mem_pin_slew_sel
);
	import scfp_pkg::*;

	// Range check
	// Both bounds are inclusive, so the high end is the last byte of a range
	function automatic logic f_in(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
		f_in = (a >= lo) && (a <= hi);
	endfunction : f_in

	// Lock is active when two or more bits are zero
	// A single flipped bit in storage cannot change the vote
	function automatic logic f_majz(input logic [2:0] b);
		f_majz = ~((b[0] & b[1]) | (b[0] & b[2]) | (b[1] & b[2]));
	endfunction : f_majz

	// Byte-lane merge for a 16-bit register
	// Lanes 2 and 3 carry nothing for these registers and are dropped
	function automatic logic [15:0] f_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
		f_merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : f_merge

	// Bus slave state
	scfp_apb_st_t  st_q,      st_d;       // Phase
	logic          pready_q,  pready_d;   // Ready flop
	logic          perr_q,    perr_d;     // Error flop
	logic [31:0]   prdata_q,  prdata_d;   // Read data flop
	// Software registers
	logic [7:0]    clkcfg_q,  clkcfg_d;   // Clock-output config
	logic [7:0]    io_zone_timing_config_q,   io_zone_timing_config_d;    // I/O zone timing
	logic [15:0]   pb0we_q,   pb0we_d;    // Program block 0 enables
	logic [15:0]   pb1we_q,   pb1we_d;    // Program block 1 enables
	logic [15:0]   dbwe_q,    dbwe_d;     // Data block enables
	// Status and protection state
	logic [7:0]    module_status_q,   module_status_d;    // Module status
	logic [2:0]    strap_q,   strap_d;    // Captured straps
	logic [1:0]    scnt_q,    scnt_d;     // Strap settle count
	logic          sdone_q,   sdone_d;    // Straps captured
	logic          wrp_q,     wrp_d;      // Global write lock
	logic          rdp_q,     rdp_d;      // Global read lock
	logic [23:0]   bend_q,    bend_d;     // Boot area end
	// Synchroniser, pins and outputs
	logic [5:0]    sy1_q;                 // First stage
	logic [5:0]    sy2_q;                 // Second stage
	logic [2:0]    eout_q,    eout_d;     // Strap pin drive
	logic [2:0]    eoe_q,     eoe_d;      // Strap pin enable
	scfp_timing_t  tim_q,     tim_d;      // Access timing
	logic          wok_q,     wok_d;      // Write allowed
	logic          wno_q,     wno_d;      // Write refused
	// Bus decode
	logic          acc;                   // Access phase
	logic          wr_en;                 // Write commit
	logic          hit;                   // Mapped address
	logic [31:0]   rd_val;                // Read mux value

	// Address decode and read mux
	// Unmapped addresses clear hit, which the bus phase turns into an error
	always_comb begin
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			`SCFP_CLKCFG_ADDR: rd_val = {24'h000000, clkcfg_q};
			`SCFP_MODULE_STATUS_ADDR:  rd_val = {24'h000000, module_status_q};
			`SCFP_IO_ZONE_TIMING_CONFIG_ADDR:  rd_val = {24'h000000, io_zone_timing_config_q};
			`SCFP_PB0WE_ADDR:  rd_val = {16'h0000, pb0we_q};
			`SCFP_PB1WE_ADDR:  rd_val = {16'h0000, pb1we_q};
			`SCFP_DBWE_ADDR:   rd_val = {16'h0000, dbwe_q};
			`SCFP_PROT_ADDR:   rd_val = {6'h00, rdp_q, wrp_q, bend_q};
			default:           hit = 1'b0;
		endcase
	end

	// Bus phase: one wait cycle, then ready
	// Ready is a flop, so the slave always answers in the second access cycle
	// A write commits only on the edge at which ready is seen high
	always_comb begin
		acc      = psel & penable;
		wr_en    = acc & pwrite & pready_q & hit;
		st_d     = st_q;
		pready_d = 1'b0;
		perr_d   = 1'b0;
		prdata_d = prdata_q;
		case (st_q)
			SCFP_IDLE: begin
				// First access cycle is the wait cycle
				// Read data is taken now so that it stands together with ready
				if (acc) begin
					st_d     = SCFP_RESP;
					pready_d = 1'b1;
					perr_d   = ~hit;
					prdata_d = (pwrite | ~hit) ? 32'h0000_0000 : rd_val;
				end
			end
			SCFP_RESP: begin
				// Transfer completes on this edge
				st_d = SCFP_IDLE;
			end
			default: begin
				st_d = SCFP_IDLE;
			end
		endcase
	end

	// Bus phase registers
	// Ready and error stand for exactly one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= SCFP_IDLE;
			pready_q <= 1'b0;
			perr_q   <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			st_q     <= st_d;
			pready_q <= pready_d;
			perr_q   <= perr_d;
			prdata_q <= prdata_d;
		end
	end

	// Software register writes
	// Only mapped writable words change; lanes outside a register are ignored
	always_comb begin
		clkcfg_d = clkcfg_q;
		io_zone_timing_config_d  = io_zone_timing_config_q;
		pb0we_d  = pb0we_q;
		pb1we_d  = pb1we_q;
		dbwe_d   = dbwe_q;
		if (wr_en) begin
			case (paddr)
				`SCFP_CLKCFG_ADDR: begin
					// Reserved bits stay zero
					if (pstrb[0]) clkcfg_d = pwdata[7:0] & `SCFP_CLKCFG_MASK;
				end
				`SCFP_IO_ZONE_TIMING_CONFIG_ADDR: begin
					if (pstrb[0]) io_zone_timing_config_d = pwdata[7:0] & `SCFP_IO_ZONE_TIMING_CONFIG_MASK;
				end
				`SCFP_PB0WE_ADDR: pb0we_d = f_merge(pb0we_q, pwdata, pstrb);
				`SCFP_PB1WE_ADDR: pb1we_d = f_merge(pb1we_q, pwdata, pstrb);
				`SCFP_DBWE_ADDR:  dbwe_d  = f_merge(dbwe_q, pwdata, pstrb);
				default: begin
					// Read-only and unmapped writes ignored
					clkcfg_d = clkcfg_q;
				end
			endcase
		end
	end

	// Software registers; only reset clears them, not power modes
	// Write enables start cleared so no section is writable before software opens it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clkcfg_q <= `SCFP_CLKCFG_RST;
			io_zone_timing_config_q  <= `SCFP_IO_ZONE_TIMING_CONFIG_RST;
			pb0we_q  <= `SCFP_WE_RST;
			pb1we_q  <= `SCFP_WE_RST;
			dbwe_q   <= `SCFP_WE_RST;
		end else begin
			clkcfg_q <= clkcfg_d;
			io_zone_timing_config_q  <= io_zone_timing_config_d;
			pb0we_q  <= pb0we_d;
			pb1we_q  <= pb1we_d;
			dbwe_q   <= dbwe_d;
		end
	end

	// Two-flop synchroniser for straps and clock levels
	// Only the second stage feeds logic; the first may be metastable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy1_q <= 6'h00;
			sy2_q <= 6'h00;
		end else begin
			sy1_q <= {slow_clk_lvl, main_clk_lvl, pll_clk_lvl, env_strap_in};
			sy2_q <= sy1_q;
		end
	end

	// Strap capture, protection word capture, busy mirror
	// Capture happens once per reset; later pin changes are not seen
	// Changes to the protection word also need a reset to take effect
	always_comb begin
		strap_d = strap_q;
		scnt_d  = scnt_q;
		sdone_d = sdone_q;
		wrp_d   = wrp_q;
		rdp_d   = rdp_q;
		bend_d  = bend_q;
		if (!sdone_q) begin
			// Wait for the synchroniser to settle, then latch once
			if (scnt_q == `SCFP_STRAP_CYC) begin
				strap_d = sy2_q[2:0];
				sdone_d = 1'b1;
				wrp_d   = f_majz(prot_word.wr_lock);
				rdp_d   = f_majz(prot_word.rd_lock);
				// Boundary never passes the largest boot area
				bend_d  = (prot_word.boot_end > `SCFP_BOOT_MAX_END) ? `SCFP_BOOT_MAX_END : prot_word.boot_end;
			end else begin
				scnt_d = scnt_q + 2'h1;
			end
		end
		module_status_d = 8'h00;
		module_status_d[2:0] = strap_q;
		module_status_d[`SCFP_ANY_BUSY_BIT]  = prog_flash_busy;
		module_status_d[`SCFP_DATA_BUSY_BIT] = data_flash_busy;
	end

	// Status registers; locks start safe until captured
	// Until capture both locks read active and the boot area is at its largest
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_q <= 3'h0;
			scnt_q  <= 2'h0;
			sdone_q <= 1'b0;
			wrp_q   <= 1'b1;
			rdp_q   <= 1'b1;
			bend_q  <= `SCFP_BOOT_MAX_END;
			module_status_q <= 8'h00;
		end else begin
			strap_q <= strap_d;
			scnt_q  <= scnt_d;
			sdone_q <= sdone_d;
			wrp_q   <= wrp_d;
			rdp_q   <= rdp_d;
			bend_q  <= bend_d;
			module_status_q <= module_status_d;
		end
	end

	// Clock-output pins: driven only while enabled
	// The level driven is the synchronised clock level, three cycles late
	// With the enable low the pad floats; the strap is read again only at the next reset
	always_comb begin
		eout_d = sy2_q[5:3];
		eoe_d  = 3'h0;
		eoe_d[0] = clkcfg_q[`SCFP_PLL_OE_BIT];
		eoe_d[1] = clkcfg_q[`SCFP_MAIN_OE_BIT];
		eoe_d[2] = clkcfg_q[`SCFP_SLOW_OE_BIT];
	end

	// CPU access timing and flash write check
	// The CPU access is judged one cycle after it is seen
	// Reads are never refused; the read lock only concerns the debugger
	always_comb begin
		logic        pm0;
		logic        pm1;
		logic        dm;
		logic        ioz;
		logic [3:0]  sec;
		logic        we;
		pm0 = f_in(cpu_req.addr, `SCFP_PM0_LO, `SCFP_PM0_HI);
		pm1 = f_in(cpu_req.addr, `SCFP_PM1_LO, `SCFP_PM1_HI);
		dm  = f_in(cpu_req.addr, `SCFP_DM_LO, `SCFP_DM_HI);
		ioz = f_in(cpu_req.addr, `SCFP_IOZ_LO, `SCFP_IOZ_HI);
		sec = dm ? cpu_req.addr[`SCFP_DM_SEC_LSB +: 4] : cpu_req.addr[`SCFP_PM_SEC_LSB +: 4];
		we  = 1'b0;
		if (pm0) we = pb0we_q[sec];
		if (pm1) we = pb1we_q[sec];
		if (dm)  we = dbwe_q[sec];
		tim_d = '0;
		if (cpu_req.valid) begin
			if (ioz) begin
				// I/O zone takes its own timing
				tim_d.valid    = 1'b1;
				tim_d.wait_cyc = io_zone_timing_config_q[`SCFP_IO_WAIT_LSB +: 3];
				tim_d.hold_cyc = io_zone_timing_config_q[`SCFP_IO_HOLD_LSB +: 2];
				tim_d.pre_idle = io_zone_timing_config_q[`SCFP_IO_PRE_BIT];
				tim_d.ext_bus  = clkcfg_q[`SCFP_EXT_BUS_BIT];
			end else if (f_in(cpu_req.addr, `SCFP_PERI0_LO, `SCFP_PERI0_HI) ||
			             f_in(cpu_req.addr, `SCFP_PERI1_LO, `SCFP_PERI1_HI)) begin
				tim_d.valid    = 1'b1;
				tim_d.wait_cyc = `SCFP_PERI_WAIT;
				tim_d.hold_cyc = `SCFP_PERI_HOLD;
				tim_d.pre_idle = `SCFP_PERI_PRE;
			end
		end
		wok_d = 1'b0;
		wno_d = 1'b0;
		if (cpu_req.valid && cpu_req.write && (pm0 || pm1 || dm)) begin
			// Boot area and locked flash refuse every write
			if (we && !wrp_q && !((pm0 || pm1) && (cpu_req.addr < bend_q))) begin
				wok_d = 1'b1;
			end else begin
				wno_d = 1'b1;
			end
		end
	end

	// Pin and check registers
	// Registering pin and check outputs keeps them free of glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eout_q <= 3'h0;
			eoe_q  <= 3'h0;
			tim_q  <= '0;
			wok_q  <= 1'b0;
			wno_q  <= 1'b0;
		end else begin
			eout_q <= eout_d;
			eoe_q  <= eoe_d;
			tim_q  <= tim_d;
			wok_q  <= wok_d;
			wno_q  <= wno_d;
		end
	end

	// Outputs straight from flops
	// Slew and bus enable bits are register bits taken directly
	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = perr_q;
	assign cpu_timing         = tim_q;
	assign flash_wr_allow     = wok_q;
	assign flash_wr_deny      = wno_q;
	assign dbg_rd_block       = rdp_q;
	assign env_strap_out      = eout_q;
	assign env_strap_oe       = eoe_q;
	assign io_zone_ext_bus_en = clkcfg_q[`SCFP_EXT_BUS_BIT];
	assign misc_pin_slew_sel  = clkcfg_q[`SCFP_MISC_SLEW_BIT];
	assign mem_pin_slew_sel   = clkcfg_q[`SCFP_MEM_SLEW_BIT];
endmodule : scfp_top

/* File: sim/scfp_cpu_model.sv */
`timescale 1ns/1ps
// CPU side: APB master plus monitored flash access pulses
module scfp_cpu_model
	import scfp_pkg::*;
(
	input  wire logic           pclk,
	input  wire logic           busy,
	output logic                psel,
	output logic                penable,
	output logic                pwrite,
	output logic [23:0]         paddr,
	output logic [31:0]         pwdata,
	output logic [3:0]          pstrb,
	input  wire logic [31:0]    prdata,
	input  wire logic           pready,
	input  wire logic           pslverr,
	output scfp_pkg::scfp_cpu_req_t cpu_req
);
	// Idle bus at time zero
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		cpu_req = '0;
	end
	// One APB transfer, held until pready is seen; the model is always in active mode
	task xfer(input logic w, input logic [23:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// One CPU access pulse; writes wait while any flash is busy
	task cpu(input logic w, input logic [23:0] a);
		while (w && busy) begin
			@(posedge pclk);
		end
		@(posedge pclk);
		cpu_req <= '{1'b1, w, a};
		@(posedge pclk);
		cpu_req.valid <= 1'b0;
		#1;
	endtask : cpu
endmodule : scfp_cpu_model

/* File: sim/scfp_checker.sv */
`timescale 1ns/1ps
`include "scfp_map.svh"
// Port-level relations of the config and protection block
module scfp_checker
	import scfp_pkg::*;
(
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [23:0]    paddr,
	input  wire logic [31:0]    pwdata,
	input  wire logic           pready,
	input  wire logic           pslverr,
	input  wire scfp_pkg::scfp_cpu_req_t cpu_req,
	input  wire scfp_pkg::scfp_timing_t  cpu_timing,
	input  wire logic           flash_wr_allow,
	input  wire logic           flash_wr_deny,
	input  wire logic           dbg_rd_block,
	input  wire scfp_pkg::scfp_prot_t    prot_word,
	input  wire logic [2:0]     env_strap_oe,
	input  wire logic           io_zone_ext_bus_en,
	input  wire logic           misc_pin_slew_sel,
	input  wire logic           mem_pin_slew_sel
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Two or more zero bits vote the lock on
	function automatic logic mz(input logic [2:0] b);
		return (~b[0] & ~b[1]) | (~b[0] & ~b[2]) | (~b[1] & ~b[2]);
	endfunction : mz
	// Access inside a mapped flash main block
	function automatic logic fr(input logic [23:0] a);
		return (a <= `SCFP_PM1_HI) || (a >= `SCFP_DM_LO && a <= `SCFP_DM_HI);
	endfunction : fr
	// Helper terms for the assertions below
	logic       cfg_wr;    // Clock config write committing at this edge
	logic [2:0] cfg_dir;   // Direct config bits being written
	logic [2:0] cfg_oe;    // Pin enable bits being written
	logic [2:0] cfg_now;   // Direct config bits as shown
	logic       peri_acc;  // CPU access to a fixed-timing peripheral range
	logic       ioz_acc;   // CPU access to the I/O zone
	assign cfg_wr   = psel && penable && pready && pwrite && paddr == `SCFP_CLKCFG_ADDR;
	assign cfg_dir  = {pwdata[6], pwdata[5], pwdata[0]};
	assign cfg_oe   = pwdata[3:1];
	assign cfg_now  = {mem_pin_slew_sel, misc_pin_slew_sel, io_zone_ext_bus_en};
	assign peri_acc = cpu_req.valid && (cpu_req.addr >= `SCFP_PERI0_LO && cpu_req.addr <= `SCFP_PERI0_HI ||
		cpu_req.addr >= `SCFP_PERI1_LO && cpu_req.addr < `SCFP_IOZ_LO);
	assign ioz_acc  = cpu_req.valid && cpu_req.addr >= `SCFP_IOZ_LO && cpu_req.addr <= `SCFP_IOZ_HI;
	// Setup cycle followed by first access cycle
	sequence s_acc1;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_cpu_wr;
		cpu_req.valid && cpu_req.write;
	endsequence
	a_apb_answer: assert property (s_acc1 |=> pready) else $error("no answer in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_periph_timing: assert property (peri_acc |=> cpu_timing == {1'b1, 3'h1, 2'h0, 1'b1, 1'b0})
		else $error("peripheral timing wrong");
	a_ioz_bus: assert property (ioz_acc |=> cpu_timing.ext_bus == $past(io_zone_ext_bus_en))
		else $error("io zone bus flag wrong");
	a_cfg_direct: assert property ($changed(cfg_now)
		|-> $past(cfg_wr) && cfg_now == $past(cfg_dir)) else $error("config bits moved without write");
	a_cfg_pin_oe: assert property ($changed(env_strap_oe)
		|-> $past(cfg_wr, 2) && env_strap_oe == $past(cfg_oe, 2)) else $error("pin enables moved without write");
	a_boot_deny: assert property (s_cpu_wr ##0 cpu_req.addr < prot_word.boot_end
		&& cpu_req.addr < `SCFP_BOOT_MAX_END |=> flash_wr_deny && !flash_wr_allow) else $error("boot area write passed");
	a_lock_deny: assert property (s_cpu_wr ##0 fr(cpu_req.addr) && mz(prot_word.wr_lock)
		|=> flash_wr_deny && !flash_wr_allow) else $error("locked write passed");
	a_read_free: assert property (cpu_req.valid && !cpu_req.write |=> !flash_wr_deny && !flash_wr_allow)
		else $error("cpu read judged");
	a_read_lock: assert property (mz(prot_word.rd_lock) |-> dbg_rd_block) else $error("read lock not shown");
endmodule : scfp_checker
bind scfp_top scfp_checker i_scfp_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
	.cpu_timing(cpu_timing), .flash_wr_allow(flash_wr_allow), .flash_wr_deny(flash_wr_deny),
	.dbg_rd_block(dbg_rd_block), .prot_word(prot_word), .env_strap_oe(env_strap_oe),
	.io_zone_ext_bus_en(io_zone_ext_bus_en), .misc_pin_slew_sel(misc_pin_slew_sel), .mem_pin_slew_sel(mem_pin_slew_sel));

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "scfp_map.svh"
module tb_top;
	import scfp_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, wa, wd, drb, ext, mis, mem, pb, db;
	logic [23:0]   paddr;
	logic [31:0]   pwdata, prdata, lf, r;
	logic [3:0]    pstrb;
	logic [2:0]    sin, sout, soe, lvl;
	logic          e;
	scfp_cpu_req_t req;
	scfp_timing_t  tim;
	scfp_prot_t    prot;
	int            failures, n_checks;
	logic [23:0]   at[9] = '{24'h000800, 24'h000FFF, 24'h001000, 24'h002000, 24'h004000,
		24'h020000, 24'h03E000, 24'h0E0000, 24'h0E0200};
	logic [1:0]    ex[9] = '{2'b01, 2'b01, 2'b10, 2'b10, 2'b01, 2'b01, 2'b10, 2'b10, 2'b01};
	// Clock, 25 ns period
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	scfp_top i_scfp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_req(req), .cpu_timing(tim), .flash_wr_allow(wa), .flash_wr_deny(wd), .dbg_rd_block(drb),
		.prot_word(prot), .prog_flash_busy(pb), .data_flash_busy(db), .env_strap_in(sin), .env_strap_out(sout),
		.env_strap_oe(soe), .pll_clk_lvl(lvl[0]), .main_clk_lvl(lvl[1]), .slow_clk_lvl(lvl[2]),
		.io_zone_ext_bus_en(ext), .misc_pin_slew_sel(mis), .mem_pin_slew_sel(mem));
	scfp_cpu_model i_scfp_cpu_model (.pclk(pclk), .busy(pb | db), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_req(req));
	// Next random word
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up
	task wr(input logic [23:0] a, input logic [31:0] d);
		i_scfp_cpu_model.xfer(1'b1, a, d, r, e);
	endtask : wr
	task rd(input logic [23:0] a);
		i_scfp_cpu_model.xfer(1'b0, a, 32'h0, r, e);
	endtask : rd
	// Reset with a given protection word, settle past capture
	task rst(input logic [2:0] wl, input logic [2:0] rl);
		presetn <= 1'b0;
		prot <= '{wl, rl, 24'h001000};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
	endtask : rst
	// Watchdog
	initial begin
		#(25 * 20000);
		failures++;
		wrap_up();
	end
	initial begin
		{presetn, pb, db} = '0;
		sin = 3'h5;
		lvl = 3'h0;
		prot = '0;
		lf = 32'd85608;
		rst(3'b001, 3'b100);
		// Reset values, straps, lock active
		rd(`SCFP_CLKCFG_ADDR); chk(r, 32'h0);
		for (int i = 0; i < 3; i++) begin
			rd(`SCFP_PB0WE_ADDR + 24'(4 * i)); chk(r, 32'h0);
		end
		@(posedge pclk) sin <= 3'h2;
		rd(`SCFP_MODULE_STATUS_ADDR); chk(r, 32'h5);
		rd(24'hFFF9F0); chk({31'h0, e}, 32'h1);
		chk({31'h0, drb}, 32'h1);
		wr(`SCFP_PB0WE_ADDR, 32'h2);
		i_scfp_cpu_model.cpu(1'b1, 24'h002000); chk({wa, wd}, 2'b01);
		$display("test reset_lock done");
		// Busy mirrors, reserved bits zero
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk) {db, pb} <= 2'(i);
			rd(`SCFP_MODULE_STATUS_ADDR); chk(r, {27'h0, 2'(i), 3'h5});
		end
		@(posedge pclk) {db, pb} <= 2'b00;
		$display("test busy done");
		// Random clock-output configuration
		repeat (12) begin
			lf = lfsr(lf);
			wr(`SCFP_CLKCFG_ADDR, lf);
			wr(`SCFP_MODULE_STATUS_ADDR, lf);
			rd(`SCFP_CLKCFG_ADDR); chk(r, {24'h0, lf[7:0] & 8'h6F});
			@(posedge pclk) lvl <= lf[10:8];
			repeat (4) @(posedge pclk);
			chk(soe, lf[3:1]);
			chk(sout & soe, lf[10:8] & lf[3:1]);
			chk({mem, mis, ext}, {lf[6], lf[5], lf[0]});
		end
		rd(`SCFP_MODULE_STATUS_ADDR); chk(r, 32'h5);
		$display("test clock_config done");
		// Lock off: section decode and access timing
		rst(3'b110, 3'b011);
		chk({31'h0, drb}, 32'h0);
		wr(`SCFP_PB0WE_ADDR, 32'h3);
		wr(`SCFP_PB1WE_ADDR, 32'h8000);
		wr(`SCFP_DBWE_ADDR, 32'h1);
		wr(`SCFP_CLKCFG_ADDR, 32'h1);
		wr(`SCFP_IO_ZONE_TIMING_CONFIG_ADDR, 32'h2B);
		for (int i = 0; i < 9; i++) begin
			i_scfp_cpu_model.cpu(1'b1, at[i]); chk({wa, wd}, ex[i]);
		end
		i_scfp_cpu_model.cpu(1'b0, 24'h004000); chk({wa, wd}, 2'b00);
		i_scfp_cpu_model.cpu(1'b0, 24'h0EF000); chk(tim, 8'h92);
		i_scfp_cpu_model.cpu(1'b0, 24'hFF1000); chk(tim, 8'h92);
		i_scfp_cpu_model.cpu(1'b0, 24'hFFFB00); chk(tim, 8'hB7);
		for (int i = 0; i < 3; i++) begin
			wr(`SCFP_PB0WE_ADDR + 24'(4 * i), 32'h0);
		end
		i_scfp_cpu_model.cpu(1'b1, 24'h002000); chk({wa, wd}, 2'b01);
		$display("test protection done");
		wrap_up();
	end
endmodule : tb_top
